//--- pmdc_pkg.sv
/*
 * Shared constants and carrier types for the PLL multiplier and divider
 * configuration block: register indices, field positions, reset values,
 * code limits and the packed structs that carry settings.
 * Assumes the user imports the whole package.
 */
package pmdc_pkg;

    // Register indices; the bus word address equals the index
    localparam logic [7:0] PMDC_IDX_MULT_HIGH = 8'h36;
    localparam logic [7:0] PMDC_IDX_FRAC_LOW  = 8'h37;
    localparam logic [7:0] PMDC_IDX_INT_LOW   = 8'h38;
    localparam logic [7:0] PMDC_IDX_N_MIC     = 8'h39;
    localparam logic [7:0] PMDC_IDX_M_ADC     = 8'h3A;
    localparam logic [7:0] PMDC_IDX_AUTO      = 8'h40;
    localparam logic [7:0] PMDC_IDX_STATUS    = 8'h41;
    localparam logic [7:0] PMDC_IDX_DIV_EN    = 8'h44;

    // Reset values
    localparam logic [7:0] PMDC_RST_MULT_HIGH = 8'h00;
    localparam logic [7:0] PMDC_RST_FRAC_LOW  = 8'h00;
    localparam logic [7:0] PMDC_RST_INT_LOW   = 8'h08;
    localparam logic [7:0] PMDC_RST_N_MIC     = 8'h20;
    localparam logic [7:0] PMDC_RST_M_ADC     = 8'h04;
    localparam logic [2:0] PMDC_RST_DIV_EN    = 3'h0;

    // Field positions
    localparam int PMDC_FRAC_HIGH_MSB = 5;
    localparam int PMDC_INT_HIGH_BIT  = 7;
    localparam int PMDC_N_MSB         = 7;
    localparam int PMDC_N_LSB         = 5;
    localparam int PMDC_MIC_MSB       = 4;
    localparam int PMDC_MIC_LSB       = 2;
    localparam int PMDC_M_MSB         = 7;
    localparam int PMDC_M_LSB         = 2;
    localparam int PMDC_ADC_MSB       = 1;
    localparam int PMDC_ADC_LSB       = 0;
    localparam int PMDC_EN_N_BIT      = 2;
    localparam int PMDC_EN_M_BIT      = 1;
    localparam int PMDC_EN_MIC_BIT    = 0;

    // Writable bits of the shared registers
    localparam logic [7:0] PMDC_MASK_MULT_HIGH = 8'hBF;
    localparam logic [7:0] PMDC_MASK_N_MIC     = 8'hFC;

    // Code limits and decoded ratios for code zero
    localparam logic [13:0] PMDC_FRAC_MAX    = 14'h270F;
    localparam logic [2:0]  PMDC_MIC_MAX     = 3'h4;
    localparam logic [1:0]  PMDC_ADC_MAX     = 2'h2;
    localparam logic [3:0]  PMDC_N_ZERO_RAT  = 4'h8;
    localparam logic [6:0]  PMDC_M_ZERO_RAT  = 7'h40;

    // Raw codes as held in the registers
    typedef struct packed {
        logic [13:0] frac;
        logic [8:0]  intg;
        logic [2:0]  n_code;
        logic [5:0]  m_code;
        logic [2:0]  mic_code;
        logic [1:0]  adc_code;
        logic        n_en;
        logic        m_en;
        logic        mic_en;
    } pmdc_codes_s;

    // Settings as the clock tree uses them; a ratio of zero means stopped
    typedef struct packed {
        logic [13:0] frac;
        logic [8:0]  intg;
        logic [3:0]  n_ratio;
        logic [6:0]  m_ratio;
        logic [4:0]  mic_ratio;
        logic [2:0]  adc_ratio;
    } pmdc_ratios_s;

endpackage : pmdc_pkg

//--- pmdc_ratio_decode.sv
/*
 * Combinational decode of raw multiplier and divider codes into ratios,
 * plus flags for codes that software must not use.
 * Assumes a registered consumer; nothing here is clocked.
 */
`timescale 1ns/10ps
`default_nettype none

module pmdc_ratio_decode
    import pmdc_pkg::*;
(
    // Raw codes
    input  wire pmdc_codes_s  codes,
    // Decoded settings and reserved-code flags
    output var  pmdc_ratios_s ratios,
    output logic [3:0]        rsv_flags
);

    // Ratio decode; a disabled divider reports zero
    always_comb begin
        ratios.frac = codes.frac;
        ratios.intg = codes.intg;
        ratios.n_ratio = (codes.n_code == 3'h0) ? PMDC_N_ZERO_RAT
                                                : {1'b0, codes.n_code};
        ratios.m_ratio = (codes.m_code == 6'h00) ? PMDC_M_ZERO_RAT
                                                 : {1'b0, codes.m_code};
        // Reserved mic and ADC codes decode to zero so a stray value stops the clock
        ratios.mic_ratio = (codes.mic_code > PMDC_MIC_MAX) ? 5'h00
                                                           : 5'h01 << codes.mic_code;
        ratios.adc_ratio = (codes.adc_code > PMDC_ADC_MAX) ? 3'h0
                                                           : 3'h1 << codes.adc_code;
        if (!codes.n_en) begin
            ratios.n_ratio = 4'h0;
        end
        if (!codes.m_en) begin
            ratios.m_ratio = 7'h00;
        end
        if (!codes.mic_en) begin
            ratios.mic_ratio = 5'h00;
        end
    end

    // Codes that software must not program
    always_comb begin
        rsv_flags[0] = codes.frac > PMDC_FRAC_MAX;
        rsv_flags[1] = codes.intg == 9'h000;
        rsv_flags[2] = codes.mic_code > PMDC_MIC_MAX;
        rsv_flags[3] = codes.adc_code > PMDC_ADC_MAX;
    end

endmodule : pmdc_ratio_decode

`default_nettype wire

//--- pmdc_top.sv
/*
 * PLL multiplier and divider configuration registers with an Avalon-MM
 * slave, ratio decode, atomic multiplier update and automatic override.
 * Assumes a single 250 MHz clock and that the auto-detect settings come
 * from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pmdc_top
    import pmdc_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // Avalon-MM slave, word addressed
    input  wire logic [7:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    // Settings found by the automatic clock detector
    input  wire pmdc_ratios_s auto_cfg,
    // Settings driven to the clock tree
    output var  pmdc_ratios_s clk_cfg,
    output logic              auto_active
);

    // Register state
    logic [7:0]   mult_high_r;
    logic [5:0]   frac_high_live_r;
    logic         int_high_live_r;
    logic [7:0]   frac_low_r;
    logic [7:0]   int_low_r;
    logic [7:0]   n_mic_r;
    logic [7:0]   m_adc_r;
    logic [2:0]   div_en_r;
    logic         auto_en_r;
    logic         frac_pend_r;
    logic         int_pend_r;
    logic         wait_r;
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    pmdc_ratios_s cfg_r;
    pmdc_ratios_s cfg_nxt;
    logic         active_r;

    // Decode nets
    pmdc_codes_s  codes;
    pmdc_ratios_s ratios;
    logic [3:0]   rsv_flags;
    logic [13:0]  frac_live;
    logic [8:0]   int_live;
    logic         req;
    logic         acc_wr;

    // Bus handshake terms
    assign req    = avs_read | avs_write;
    assign acc_wr = avs_write & ~wait_r;

    // Waitrequest drops one cycle after a request appears, for one cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 1'b1;
        end else if (!wait_r) begin
            wait_r <= 1'b1;
        end else if (req) begin
            wait_r <= 1'b0;
        end
    end

    // Multiplier high bits: staged here, read back with reserved bit 6 as zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mult_high_r <= PMDC_RST_MULT_HIGH;
        end else if (acc_wr && avs_address == PMDC_IDX_MULT_HIGH) begin
            mult_high_r <= avs_writedata[7:0] & PMDC_MASK_MULT_HIGH;
        end
    end

    // Fractional low byte; its write commits the staged high bits with it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            frac_low_r       <= PMDC_RST_FRAC_LOW;
            frac_high_live_r <= 6'h00;
        end else if (acc_wr && avs_address == PMDC_IDX_FRAC_LOW) begin
            frac_low_r       <= avs_writedata[7:0];
            frac_high_live_r <= mult_high_r[PMDC_FRAC_HIGH_MSB:0];
        end
    end

    // Integer low byte; its write commits the staged high bit with it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            int_low_r       <= PMDC_RST_INT_LOW;
            int_high_live_r <= 1'b0;
        end else if (acc_wr && avs_address == PMDC_IDX_INT_LOW) begin
            int_low_r       <= avs_writedata[7:0];
            int_high_live_r <= mult_high_r[PMDC_INT_HIGH_BIT];
        end
    end

    // Pending flags show a staged high part not yet committed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            frac_pend_r <= 1'b0;
            int_pend_r  <= 1'b0;
        end else if (acc_wr) begin
            if (avs_address == PMDC_IDX_MULT_HIGH) begin
                frac_pend_r <= 1'b1;
                int_pend_r  <= 1'b1;
            end
            if (avs_address == PMDC_IDX_FRAC_LOW) begin
                frac_pend_r <= 1'b0;
            end
            if (avs_address == PMDC_IDX_INT_LOW) begin
                int_pend_r <= 1'b0;
            end
        end
    end

    // Divider code registers; reserved low bits of 0x39 never store
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            n_mic_r <= PMDC_RST_N_MIC;
            m_adc_r <= PMDC_RST_M_ADC;
        end else if (acc_wr) begin
            if (avs_address == PMDC_IDX_N_MIC) begin
                n_mic_r <= avs_writedata[7:0] & PMDC_MASK_N_MIC;
            end
            if (avs_address == PMDC_IDX_M_ADC) begin
                m_adc_r <= avs_writedata[7:0];
            end
        end
    end

    // Divider enables and automatic detection switch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_en_r  <= PMDC_RST_DIV_EN;
            auto_en_r <= 1'b0;
        end else if (acc_wr) begin
            if (avs_address == PMDC_IDX_DIV_EN) begin
                div_en_r <= avs_writedata[2:0];
            end
            if (avs_address == PMDC_IDX_AUTO) begin
                auto_en_r <= avs_writedata[0];
            end
        end
    end

    // Live multipliers are built only from committed parts
    assign frac_live = {frac_high_live_r, frac_low_r};
    assign int_live  = {int_high_live_r, int_low_r};

    // Gather raw codes for the decoder
    always_comb begin
        codes.frac     = frac_live;
        codes.intg     = int_live;
        codes.n_code   = n_mic_r[PMDC_N_MSB:PMDC_N_LSB];
        codes.mic_code = n_mic_r[PMDC_MIC_MSB:PMDC_MIC_LSB];
        codes.m_code   = m_adc_r[PMDC_M_MSB:PMDC_M_LSB];
        codes.adc_code = m_adc_r[PMDC_ADC_MSB:PMDC_ADC_LSB];
        codes.n_en     = div_en_r[PMDC_EN_N_BIT];
        codes.m_en     = div_en_r[PMDC_EN_M_BIT];
        codes.mic_en   = div_en_r[PMDC_EN_MIC_BIT];
    end

    pmdc_ratio_decode u_decode (
        .codes     (codes),
        .ratios    (ratios),
        .rsv_flags (rsv_flags)
    );

    // Auto detection overrides every programmed field
    always_comb begin
        cfg_nxt = auto_en_r ? auto_cfg : ratios;
    end

    // Settings to the clock tree leave from flops to keep glitches off it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_r    <= '0;
            active_r <= 1'b0;
        end else begin
            cfg_r    <= cfg_nxt;
            active_r <= auto_en_r;
        end
    end

    assign clk_cfg     = cfg_r;
    assign auto_active = active_r;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address)
            PMDC_IDX_MULT_HIGH: rdata_nxt[7:0] = mult_high_r;
            PMDC_IDX_FRAC_LOW:  rdata_nxt[7:0] = frac_low_r;
            PMDC_IDX_INT_LOW:   rdata_nxt[7:0] = int_low_r;
            PMDC_IDX_N_MIC:     rdata_nxt[7:0] = n_mic_r & PMDC_MASK_N_MIC;
            PMDC_IDX_M_ADC:     rdata_nxt[7:0] = m_adc_r;
            PMDC_IDX_AUTO:      rdata_nxt[0]   = auto_en_r;
            PMDC_IDX_STATUS:    rdata_nxt[7:0] = {1'b0, rsv_flags, active_r,
                                                  int_pend_r, frac_pend_r};
            PMDC_IDX_DIV_EN:    rdata_nxt[2:0] = div_en_r;
            default:            rdata_nxt      = 32'h0000_0000;
        endcase
    end

    // Read data is captured as waitrequest drops and holds through it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (wait_r && avs_read) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // Programmed fractional code reaches the output one edge later
    AST_FRAC_JOIN: assert property (@(posedge clk_sys) disable iff (!resetn)
        !auto_en_r |=> cfg_r.frac == $past(frac_live))
        else $error("fraction output does not match joined code");

    // A legal fractional code stays within range on the output
    AST_FRAC_RANGE: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && frac_live <= PMDC_FRAC_MAX) |=> cfg_r.frac <= PMDC_FRAC_MAX)
        else $error("legal fraction code left range");

    // Integer output is the nine-bit joined code
    AST_INT_JOIN: assert property (@(posedge clk_sys) disable iff (!resetn)
        !auto_en_r |=> cfg_r.intg == $past(int_live))
        else $error("integer output does not match joined code");

    // Integer low byte comes out of reset at eight
    AST_INT_RESET: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> int_low_r == PMDC_RST_INT_LOW)
        else $error("integer low byte reset value wrong");

    // N code zero selects divide by eight
    AST_N_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.n_en && codes.n_code == 3'h0) |=> cfg_r.n_ratio == 4'h8)
        else $error("n divider code zero not decoded to eight");

    // Mic code four selects divide by sixteen
    AST_MIC_16: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.mic_en && codes.mic_code == 3'h4)
        |=> cfg_r.mic_ratio == 5'h10)
        else $error("mic divider code four not decoded to sixteen");

    // M code zero selects divide by sixty-four
    AST_M_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.m_en && codes.m_code == 6'h00) |=> cfg_r.m_ratio == 7'h40)
        else $error("m divider code zero not decoded to sixty-four");

    // ADC code two selects divide by four
    AST_ADC_4: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.adc_code == 2'h2) |=> cfg_r.adc_ratio == 3'h4)
        else $error("adc modulator code two not decoded to four");

    // Auto detection replaces the whole setting
    AST_AUTO_OVR: assert property (@(posedge clk_sys) disable iff (!resetn)
        auto_en_r |=> (cfg_r == $past(auto_cfg)) && auto_active)
        else $error("auto settings not passed to output");

    // Reserved bits of 0x39 read as zero when data is handed back
    AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        (avs_read && !wait_r && avs_address == PMDC_IDX_N_MIC)
        |-> avs_readdata[1:0] == 2'h0)
        else $error("reserved bits of n and mic register read nonzero");

    // High bits register clears at reset
    AST_HIGH_RESET: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (mult_high_r == 8'h00) && (frac_high_live_r == 6'h00))
        else $error("multiplier high bits not zero after reset");

    // A disabled n divider reports a stopped ratio
    AST_N_DISABLED: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && !div_en_r[PMDC_EN_N_BIT]) |=> cfg_r.n_ratio == 4'h0)
        else $error("disabled n divider still running");

    // Writing the high bits alone leaves both live multipliers untouched
    AST_ATOMIC: assert property (@(posedge clk_sys) disable iff (!resetn)
        (acc_wr && avs_address == PMDC_IDX_MULT_HIGH)
        |=> $stable(frac_high_live_r) && $stable(int_high_live_r) && frac_pend_r)
        else $error("multiplier high part took effect without low byte");

    // A nonzero N code divides by the code itself
    AST_N_CODE: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.n_en && codes.n_code != 3'h0)
        |=> cfg_r.n_ratio == {1'b0, $past(codes.n_code)})
        else $error("n divider code not passed through as ratio");

    // A nonzero M code divides by the code itself
    AST_M_CODE: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.m_en && codes.m_code != 6'h00)
        |=> cfg_r.m_ratio == {1'b0, $past(codes.m_code)})
        else $error("m divider code not passed through as ratio");

    // A reserved mic code stops that clock rather than guessing a ratio
    AST_MIC_RSV: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.mic_code > PMDC_MIC_MAX) |=> cfg_r.mic_ratio == 5'h00)
        else $error("reserved mic divider code not stopped");

    // The reserved ADC modulator code stops that clock
    AST_ADC_RSV: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && codes.adc_code > PMDC_ADC_MAX) |=> cfg_r.adc_ratio == 3'h0)
        else $error("reserved adc modulator code not stopped");

    // A disabled m divider reports a stopped ratio
    AST_M_DISABLED: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && !div_en_r[PMDC_EN_M_BIT]) |=> cfg_r.m_ratio == 7'h00)
        else $error("disabled m divider still running");

    // A disabled mic divider reports a stopped ratio
    AST_MIC_DISABLED: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!auto_en_r && !div_en_r[PMDC_EN_MIC_BIT]) |=> cfg_r.mic_ratio == 5'h00)
        else $error("disabled mic divider still running");

    // Waitrequest is low for exactly one cycle per request
    AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(wait_r) |=> wait_r)
        else $error("waitrequest low for more than one cycle");

endmodule : pmdc_top

`default_nettype wire

//--- pmdc_bench.sv
/*
 * Self-checking bench for the PLL multiplier and divider configuration block:
 * Avalon-MM register traffic, decode tables, paired multiplier commits,
 * automatic override and reset values, checked against a reference copy.
 * Assumes the design checks its own assertions and a single clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pmdc_bench
    import pmdc_pkg::*;
();
    // Design ports
    logic         clk_sys;
    logic         resetn;
    logic [7:0]   avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    pmdc_ratios_s auto_cfg;
    pmdc_ratios_s clk_cfg;
    logic         auto_active;
    // Bench state
    int           n_fail;
    int           n_checks;
    integer       seed;
    logic [31:0]  rd;
    logic [63:0]  rnd;
    int           fr;
    int           ig;
    logic [7:0]   addrs [8] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h40, 8'h44, 8'h50};
    // Reference copy of the register file
    logic [7:0]   m_hi, m_flo, m_ilo, m_nm, m_ma;
    logic [5:0]   m_fhi;
    logic         m_ihi, m_auto, f_stg, i_stg;
    logic [2:0]   m_en;

    pmdc_top DUT (
        .clk_sys         (clk_sys),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .auto_cfg        (auto_cfg),
        .clk_cfg         (clk_cfg),
        .auto_active     (auto_active)
    );

    // Free-running 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Expected settings worked out from the reference copy
    function automatic pmdc_ratios_s exp_cfg();
        pmdc_ratios_s e;
        e.frac      = {m_fhi, m_flo};
        e.intg      = {m_ihi, m_ilo};
        e.n_ratio   = !m_en[2] ? 4'h0 : (m_nm[7:5] == 3'h0) ? 4'h8 : {1'b0, m_nm[7:5]};
        e.m_ratio   = !m_en[1] ? 7'h00 : (m_ma[7:2] == 6'h00) ? 7'h40 : {1'b0, m_ma[7:2]};
        e.mic_ratio = (!m_en[0] || m_nm[4:2] > 3'h4) ? 5'h00 : 5'h01 << m_nm[4:2];
        e.adc_ratio = (m_ma[1:0] == 2'h3) ? 3'h0 : 3'h1 << m_ma[1:0];
        if (m_auto) begin
            e = auto_cfg;
        end
        return e;
    endfunction : exp_cfg

    // Expected read data; unmapped places read zero
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h36:   return {24'h0, m_hi};
            8'h37:   return {24'h0, m_flo};
            8'h38:   return {24'h0, m_ilo};
            8'h39:   return {24'h0, m_nm};
            8'h3A:   return {24'h0, m_ma};
            8'h40:   return {31'h0, m_auto};
            8'h44:   return {29'h0, m_en};
            default: return 32'h0;
        endcase
    endfunction : exp_rd

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // The slave answers one edge after taking the request, seen at the second edge
        check(64'(n), 64'h2);
    endtask : bus

    task automatic model_reset();
        m_hi   = 8'h00;
        m_flo  = 8'h00;
        m_ilo  = 8'h08;
        m_nm   = 8'h20;
        m_ma   = 8'h04;
        m_fhi  = 6'h00;
        m_ihi  = 1'b0;
        m_auto = 1'b0;
        m_en   = 3'h0;
        f_stg  = 1'b0;
        i_stg  = 1'b0;
    endtask : model_reset

    // Write, then mirror it in the reference copy; high bits stay staged until committed
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        case (a)
            8'h36: begin m_hi = d[7:0] & 8'hBF; f_stg = 1'b1; i_stg = 1'b1; end
            8'h37: begin m_flo = d[7:0]; m_fhi = m_hi[5:0]; f_stg = 1'b0; end
            8'h38: begin m_ilo = d[7:0]; m_ihi = m_hi[7]; i_stg = 1'b0; end
            8'h39: m_nm = d[7:0] & 8'hFC;
            8'h3A: m_ma = d[7:0];
            8'h40: m_auto = d[0];
            8'h44: m_en = d[2:0];
            default: ;
        endcase
    endtask : wr

    task automatic rd_chk(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        check({32'h0, rd}, {32'h0, exp_rd(a)});
    endtask : rd_chk

    // Settings follow a register change one edge after the write lands and are checked after two
    task automatic cfg_chk();
        repeat (2) @(posedge clk_sys);
        #1;
        check({22'h0, clk_cfg}, {22'h0, exp_cfg()});
        check({63'h0, auto_active}, {63'h0, m_auto});
    endtask : cfg_chk

    task automatic stat_chk();
        bus(1'b0, 8'h41, 32'h0);
        check({32'h0, rd}, {57'h0, m_ma[1:0] == 2'h3, m_nm[4:2] > 3'h4,
                            {m_ihi, m_ilo} == 9'h000, {m_fhi, m_flo} > 14'h270F,
                            m_auto, i_stg, f_stg});
    endtask : stat_chk

    // Reset held for three cycles, then every register but status and the settings read back
    task automatic do_reset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        model_reset();
        foreach (addrs[i]) begin
            rd_chk(addrs[i]);
        end
        cfg_chk();
    endtask : do_reset

    // Watchdog sized well beyond the expected run of a few thousand cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        $display("MISMATCH t=%0t run did not complete", $time);
        finish_test();
    end

    initial begin
        seed = 13297;
        n_fail = 0;
        n_checks = 0;
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        auto_cfg = '0;
        do_reset();
        // Every N and mic code, reserved bits written as ones
        wr(8'h44, 32'h7);
        for (int c = 0; c < 8; c++) begin
            wr(8'h39, {24'h0, c[2:0], c[2:0], 2'h3});
            rd_chk(8'h39);
            cfg_chk();
            stat_chk();
        end
        // Every M code with all ADC modulator codes among them
        for (int c = 0; c < 64; c++) begin
            wr(8'h3A, {24'h0, c[5:0], c[1:0]});
            cfg_chk();
            stat_chk();
        end
        // Random legal multipliers committed in halves, random dividers and enables
        for (int k = 0; k < 100; k++) begin
            rnd = {$random(seed), $random(seed)};
            fr = rnd[31:0] % 10000;
            ig = 1 + rnd[63:32] % 511;
            @(posedge clk_sys);
            auto_cfg <= rnd[41:0];
            wr(8'h36, {24'h0, ig[8], 1'b0, fr[13:8]});
            cfg_chk();
            rd_chk(8'h36);
            stat_chk();
            wr(8'h37, {24'h0, fr[7:0]});
            cfg_chk();
            wr(8'h38, {24'h0, ig[7:0]});
            cfg_chk();
            wr(8'h39, {24'h0, rnd[15:13], 3'(rnd[20:18] % 5), 2'h0});
            wr(8'h3A, {24'h0, rnd[27:22], 2'(rnd[29:28] % 3)});
            wr(8'h44, {29'h0, rnd[42:40]});
            cfg_chk();
        end
        // Automatic detection overrides every programmed field
        wr(8'h40, 32'h1);
        for (int k = 0; k < 20; k++) begin
            rnd = {$random(seed), $random(seed)};
            @(posedge clk_sys);
            auto_cfg <= rnd[41:0];
            wr(8'h3A, {24'h0, rnd[7:2], 2'(rnd[1:0] % 3)});
            wr(8'h37, {24'h0, rnd[15:8]});
            cfg_chk();
        end
        stat_chk();
        wr(8'h40, 32'h0);
        cfg_chk();
        // Unmapped and read-only places, reserved bit of the high-bits register
        wr(8'h50, 32'hFF);
        rd_chk(8'h50);
        wr(8'h41, 32'hFF);
        stat_chk();
        wr(8'h36, 32'hFF);
        rd_chk(8'h36);
        cfg_chk();
        // Out-of-range fraction and zero integer codes raise their status flags
        wr(8'h37, 32'hFF);
        wr(8'h36, 32'h00);
        wr(8'h38, 32'h00);
        stat_chk();
        cfg_chk();
        // Second reset in mid-run
        do_reset();
        finish_test();
    end

endmodule : pmdc_bench

`default_nettype wire
